// ---- serial_pkg.sv ----
// Constants shared by the serial receive device and the sync master.
// Assumes one 50 MHz clock and APB access to the device registers.
// Functional notes
// - One 8-bit baud timer for both modes
// - Baud timer free runs, period from divisor
// - Async: divide by 64 or 16 times n+1
// - Sync: high-rate bit ignored, divide by 4(n+1)
// - Divisor write restarts the baud timer
// - Slave receive never idles between words
// - Single-receive enable ignored in slave mode
// - Reception continues during sleep
// - Enabled receive event wakes from sleep
// - Software selects sync slave mode bits
// - Ninth bit readable before data register
// - Software keeps address detect cleared
// - Word stored in FIFO sets flag; enable gates interrupt
// - Data read returns FIFO low eight bits
// - Overrun held until continuous enable cleared
package serial_pkg;
	// Register byte offsets
	localparam logic [7:0] TX_STATUS_CONTROL_OFS = 8'h00;
	localparam logic [7:0] RX_STATUS_CONTROL_OFS = 8'h04;
	localparam logic [7:0] BAUD_DIVISOR_OFS      = 8'h08;
	localparam logic [7:0] RX_DATA_OFS           = 8'h0C;
	localparam logic [7:0] TX_DATA_OFS           = 8'h10;
	localparam logic [7:0] INT_STATUS_OFS        = 8'h14;
	localparam logic [7:0] INT_MASK_OFS          = 8'h18;
	// tx_status_control fields
	localparam int CLOCK_SOURCE_SELECT_BIT = 7;
	localparam int SYNC_MODE_BIT           = 4;
	localparam int HIGH_RATE_SELECT_BIT    = 2;
	localparam int TX_SHIFT_EMPTY_BIT      = 1;
	localparam logic [7:0] TX_STATUS_CONTROL_RESET = 8'h02;
	localparam logic [7:0] TX_STATUS_CONTROL_WMASK = 8'hF5;
	// rx_status_control fields
	localparam int SERIAL_PORT_ENABLE_BIT    = 7;
	localparam int NINE_BIT_RX_ENABLE_BIT    = 6;
	localparam int SINGLE_RX_ENABLE_BIT      = 5;
	localparam int CONTINUOUS_RX_ENABLE_BIT  = 4;
	localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
	localparam int FRAMING_ERROR_BIT         = 2;
	localparam int OVERRUN_ERROR_BIT         = 1;
	localparam int RX_NINTH_BIT_BIT          = 0;
	localparam logic [7:0] RX_STATUS_CONTROL_RESET = 8'h00;
	localparam logic [7:0] RX_STATUS_CONTROL_WMASK = 8'hF8;
	localparam logic [7:0] BAUD_DIVISOR_RESET      = 8'h00;
	localparam logic [7:0] TX_DATA_RESET           = 8'h00;
	// Interrupt status and mask fields
	localparam int RX_INTERRUPT_FLAG_BIT = 0;
	localparam int OVERRUN_EVENT_BIT     = 1;
	localparam int INT_BITS              = 2;
	// Baud prescale ratios
	localparam logic [6:0] PRESCALE_ASYNC_LOW  = 7'd64;
	localparam logic [6:0] PRESCALE_ASYNC_HIGH = 7'd16;
	localparam logic [6:0] PRESCALE_SYNC       = 7'd4;
	// Link timing of the master end
	localparam int CLK_HZ           = 50_000_000;
	localparam int LINK_BIT_HZ      = 1_000_000;
	localparam int LINK_HALF_CYCLES = CLK_HZ / (2 * LINK_BIT_HZ);
	localparam int RX_FIFO_DEPTH    = 2;
endpackage

// ---- serial_link_if.sv ----
// Link between the external sync master and the receiving device.
// Assumes the master drives both pins; the device only listens.
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
	logic bit_clk;
	logic bit_data;
	modport dev (input bit_clk, input bit_data);
	modport host (output bit_clk, output bit_data);
endinterface
`default_nettype wire

// ---- serial_rx_dev.sv ----
// Baud generator and sync slave receive path with APB registers.
// Assumes link pins synchronous to i_clk and an APB master on i_clk.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_dev
	import serial_pkg::*;
#(
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output logic [31:0]      o_prdata,
	// System
	input  wire logic        i_sleep,
	output logic             o_irq,
	output logic             o_wake,
	output logic             o_baud_tick,
	// Link
	serial_link_if.dev       link
);
	// Elaboration check on the depth the pointers serve
	if (FIFO_DEPTH < 1 || FIFO_DEPTH > 16) begin : g_depth_check
		$error("FIFO_DEPTH out of range");
	end

	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

	logic [7:0]            tx_status_control_reg;
	logic [7:0]            rx_status_control_reg;
	logic [7:0]            baud_divisor_reg;
	logic [7:0]            tx_data_reg;
	logic [INT_BITS-1:0]   int_status_reg;
	logic [INT_BITS-1:0]   int_mask_reg;
	logic [31:0]           prdata_reg;
	logic                  overrun_error_reg;
	logic [5:0]            prescale_reg;
	logic [7:0]            baud_timer_reg;
	logic                  baud_tick_reg;
	logic                  clk_prev_reg;
	logic [8:0]            shift_reg;
	logic [3:0]            bit_cnt_reg;
	logic [8:0]            fifo_mem [FIFO_DEPTH];
	logic [PW-1:0]         rd_ptr_reg;
	logic [PW-1:0]         wr_ptr_reg;
	logic [PW:0]           count_reg;

	logic        setup;
	logic        access;
	logic        wr_en;
	logic        mapped;
	logic        divisor_write;
	logic        data_read;
	logic        sync_mode;
	logic        slave_mode;
	logic        rx_active;
	logic        fall_edge;
	logic        word_done;
	logic        fifo_full;
	logic        fifo_empty;
	logic        push;
	logic        pop;
	logic        pre_wrap;
	logic [6:0]  pre_limit;
	logic [3:0]  word_bits;
	logic [8:0]  word_in;
	logic [8:0]  fifo_head;

	////////////////////////////////////////////////////////////////////
	// APB decode
	assign setup  = i_psel & ~i_penable;
	assign access = i_psel & i_penable;
	assign wr_en  = access & i_pwrite;
	always_comb begin
		case (i_paddr)
			TX_STATUS_CONTROL_OFS, RX_STATUS_CONTROL_OFS,
			BAUD_DIVISOR_OFS, RX_DATA_OFS, TX_DATA_OFS,
			INT_STATUS_OFS, INT_MASK_OFS: mapped = 1'b1;
			default:                      mapped = 1'b0;
		endcase
	end
	assign o_pready      = 1'b1;
	assign o_pslverr     = access & ~mapped;
	assign o_prdata      = prdata_reg;
	assign divisor_write = wr_en & (i_paddr == BAUD_DIVISOR_OFS);
	assign data_read     = access & ~i_pwrite & (i_paddr == RX_DATA_OFS);

	// Empty FIFO reads as zero, never a stale or unwritten word
	assign fifo_head = fifo_empty ? 9'h000 : fifo_mem[rd_ptr_reg];

	// Read data captured in the setup cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup && !i_pwrite) begin
			case (i_paddr)
				TX_STATUS_CONTROL_OFS: prdata_reg <= {24'h0,
					tx_status_control_reg | TX_STATUS_CONTROL_RESET};
				RX_STATUS_CONTROL_OFS: prdata_reg <= {24'h0,
					rx_status_control_reg[7:3], 1'b0, overrun_error_reg,
					fifo_head[8]};
				BAUD_DIVISOR_OFS: prdata_reg <= {24'h0, baud_divisor_reg};
				RX_DATA_OFS:      prdata_reg <= {24'h0, fifo_head[7:0]};
				INT_STATUS_OFS:   prdata_reg <= {30'h0, int_status_reg};
				INT_MASK_OFS:     prdata_reg <= {30'h0, int_mask_reg};
				default:          prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_status_control_reg <= TX_STATUS_CONTROL_RESET;
			rx_status_control_reg <= RX_STATUS_CONTROL_RESET;
			baud_divisor_reg      <= BAUD_DIVISOR_RESET;
			tx_data_reg           <= TX_DATA_RESET;
			int_mask_reg          <= '0;
		end else if (wr_en) begin
			case (i_paddr)
				TX_STATUS_CONTROL_OFS: tx_status_control_reg <=
					i_pwdata[7:0] & TX_STATUS_CONTROL_WMASK;
				RX_STATUS_CONTROL_OFS: rx_status_control_reg <=
					i_pwdata[7:0] & RX_STATUS_CONTROL_WMASK;
				BAUD_DIVISOR_OFS: baud_divisor_reg <= i_pwdata[7:0];
				TX_DATA_OFS:      tx_data_reg      <= i_pwdata[7:0];
				INT_MASK_OFS:     int_mask_reg     <= i_pwdata[INT_BITS-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Baud rate generator
	assign sync_mode = tx_status_control_reg[SYNC_MODE_BIT];
	always_comb begin
		if (sync_mode)
			pre_limit = PRESCALE_SYNC;
		else if (tx_status_control_reg[HIGH_RATE_SELECT_BIT])
			pre_limit = PRESCALE_ASYNC_HIGH;
		else
			pre_limit = PRESCALE_ASYNC_LOW;
	end
	assign pre_wrap = ({1'b0, prescale_reg} >= (pre_limit - 7'd1));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prescale_reg   <= 6'h00;
			baud_timer_reg <= BAUD_DIVISOR_RESET;
			baud_tick_reg  <= 1'b0;
		end else if (divisor_write) begin
			prescale_reg   <= 6'h00;
			baud_timer_reg <= i_pwdata[7:0];
			baud_tick_reg  <= 1'b0;
		end else begin
			baud_tick_reg <= 1'b0;
			if (pre_wrap) begin
				prescale_reg <= 6'h00;
				if (baud_timer_reg == 8'h00) begin
					baud_timer_reg <= baud_divisor_reg;
					baud_tick_reg  <= 1'b1;
				end else begin
					baud_timer_reg <= baud_timer_reg - 8'h01;
				end
			end else begin
				prescale_reg <= prescale_reg + 6'h01;
			end
		end
	end
	assign o_baud_tick = baud_tick_reg;

	////////////////////////////////////////////////////////////////////
	// Sync slave receive shift path
	assign slave_mode = sync_mode
		& rx_status_control_reg[SERIAL_PORT_ENABLE_BIT]
		& ~tx_status_control_reg[CLOCK_SOURCE_SELECT_BIT];
	// Single-receive enable plays no part; i_sleep not gating
	assign rx_active = slave_mode
		& rx_status_control_reg[CONTINUOUS_RX_ENABLE_BIT]
		& ~overrun_error_reg;
	assign word_bits = rx_status_control_reg[NINE_BIT_RX_ENABLE_BIT]
		? 4'd9 : 4'd8;
	assign fall_edge = clk_prev_reg & ~link.bit_clk;
	assign word_done = rx_active & fall_edge & (bit_cnt_reg == word_bits - 4'd1);
	assign word_in   = rx_status_control_reg[NINE_BIT_RX_ENABLE_BIT]
		? {link.bit_data, shift_reg[8:1]}
		: {1'b0, link.bit_data, shift_reg[8:2]};

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_prev_reg <= 1'b0;
			shift_reg    <= 9'h000;
			bit_cnt_reg  <= 4'h0;
		end else begin
			clk_prev_reg <= link.bit_clk;
			if (!rx_active) begin
				bit_cnt_reg <= 4'h0;
			end else if (fall_edge) begin
				shift_reg <= {link.bit_data, shift_reg[8:1]};
				// Straight on to the next word, no idle state
				bit_cnt_reg <= word_done ? 4'h0 : bit_cnt_reg + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receive FIFO
	assign fifo_full  = (count_reg == (PW+1)'(FIFO_DEPTH));
	assign fifo_empty = (count_reg == '0);
	assign push = word_done & ~fifo_full;
	assign pop  = data_read & ~fifo_empty;

	always_ff @(posedge i_clk) begin
		if (push)
			fifo_mem[wr_ptr_reg] <= word_in;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_ptr_reg <= '0;
			wr_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(FIFO_DEPTH - 1))
					? '0 : wr_ptr_reg + PW'(1);
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(FIFO_DEPTH - 1))
					? '0 : rd_ptr_reg + PW'(1);
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Overrun and interrupts
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			overrun_error_reg <= 1'b0;
		else if (word_done && fifo_full)
			overrun_error_reg <= 1'b1;
		else if (!rx_status_control_reg[CONTINUOUS_RX_ENABLE_BIT])
			overrun_error_reg <= 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_status_reg <= '0;
		end else begin
			// Set beats a same-cycle write-one clear
			int_status_reg[RX_INTERRUPT_FLAG_BIT] <= push
				| (int_status_reg[RX_INTERRUPT_FLAG_BIT]
				& ~(wr_en && i_paddr == INT_STATUS_OFS
				&& i_pwdata[RX_INTERRUPT_FLAG_BIT]));
			int_status_reg[OVERRUN_EVENT_BIT] <= (word_done & fifo_full)
				| (int_status_reg[OVERRUN_EVENT_BIT]
				& ~(wr_en && i_paddr == INT_STATUS_OFS
				&& i_pwdata[OVERRUN_EVENT_BIT]));
		end
	end
	assign o_irq  = |(int_status_reg & int_mask_reg);
	assign o_wake = i_sleep & o_irq;
endmodule
`default_nettype wire

// ---- serial_sync_master.sv ----
// External sync master: clocks words out on the link, LSB first.
// Assumes the device samples data on the falling bit clock edge.
`timescale 1ns/1ps
`default_nettype none
module serial_sync_master
	import serial_pkg::*;
#(
	parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// User request
	input  wire logic       i_start,
	input  wire logic       i_nine,
	input  wire logic [8:0] i_word,
	output logic            o_busy,
	output logic            o_done,
	// Link
	serial_link_if.host     link
);
	// Elaboration check on the half period the divider serves
	if (HALF_CYCLES < 2 || HALF_CYCLES > 65535) begin : g_half_check
		$error("HALF_CYCLES out of range");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW  = 2'b01,
		ST_HIGH = 2'b10
	} master_state_e;

	master_state_e state_reg;
	logic [15:0]   div_reg;
	logic [8:0]    word_reg;
	logic [3:0]    left_reg;
	logic          clk_reg;
	logic          data_reg;
	logic          done_reg;
	logic          half_end;

	assign half_end = (div_reg == 16'(HALF_CYCLES - 1));

	////////////////////////////////////////////////////////////////////
	// One bit per clock period, data set at the rise, held past the fall
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			div_reg   <= 16'h0000;
			word_reg  <= 9'h000;
			left_reg  <= 4'h0;
			clk_reg   <= 1'b0;
			data_reg  <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (i_start) begin
						word_reg  <= i_word;
						left_reg  <= i_nine ? 4'd9 : 4'd8;
						div_reg   <= 16'h0000;
						state_reg <= ST_LOW;
					end
				end
				ST_LOW: begin
					div_reg <= half_end ? 16'h0000 : div_reg + 16'h0001;
					if (half_end) begin
						clk_reg   <= 1'b1;
						data_reg  <= word_reg[0];
						word_reg  <= {1'b0, word_reg[8:1]};
						state_reg <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					div_reg <= half_end ? 16'h0000 : div_reg + 16'h0001;
					if (half_end) begin
						clk_reg <= 1'b0;
						if (left_reg == 4'd1) begin
							done_reg  <= 1'b1;
							state_reg <= ST_IDLE;
						end else begin
							left_reg  <= left_reg - 4'd1;
							state_reg <= ST_LOW;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign link.bit_clk  = clk_reg;
	assign link.bit_data = data_reg;
	assign o_busy        = (state_reg != ST_IDLE);
	assign o_done        = done_reg;
endmodule
`default_nettype wire

// ---- serial_link_chk.sv ----
// Concurrent checks on the sync link and the user sides of both ends.
// Assumes one clock domain; instantiated beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module serial_link_chk #(
	parameter int HALF = 4
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Link and master user side
	input  wire logic bit_clk,
	input  wire logic bit_data,
	input  wire logic i_start,
	input  wire logic o_busy,
	input  wire logic o_done,
	// Device system side
	input  wire logic i_sleep,
	input  wire logic o_irq,
	input  wire logic o_wake,
	input  wire logic o_baud_tick
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_data_hold:
	assert property (bit_clk && $past(bit_clk) |-> $stable(bit_data))
		else $error("data moved while bit clock high");
	a_high_width:
	assert property ($rose(bit_clk) |-> ##HALF $fell(bit_clk))
		else $error("bit clock high phase of wrong length");
	a_idle_low:
	assert property (!o_busy |-> !bit_clk)
		else $error("bit clock high outside a word");
	a_busy_start:
	assert property ($rose(o_busy) |-> $past(i_start) && !bit_clk)
		else $error("busy without start");
	a_busy_holds:
	assert property ($fell(o_busy) |-> $fell(bit_clk) && o_done)
		else $error("busy ended off the last falling edge");
	a_done_pulse:
	assert property (o_done |-> !bit_clk ##1 (!o_done && !o_busy))
		else $error("done not a single pulse");
	a_wake_rule:
	assert property (o_wake == (i_sleep && o_irq))
		else $error("wake not sleep and irq");
	a_tick_gap:
	assert property (o_baud_tick |=> !o_baud_tick [*3])
		else $error("baud ticks too close");
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Bench joining the sync master and the receive device over the link.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import serial_pkg::*;
	localparam int HALF = 4;
	logic        i_clk      = 1'b0;
	logic        i_rst_n    = 1'b0;
	logic        i_psel     = 1'b0;
	logic        i_penable  = 1'b0;
	logic        i_pwrite   = 1'b0;
	logic [7:0]  i_paddr    = 8'h00;
	logic [31:0] i_pwdata   = 32'h0;
	logic        i_sleep    = 1'b0;
	logic        i_start    = 1'b0;
	logic        i_nine     = 1'b0;
	logic [8:0]  i_word     = 9'h000;
	logic        o_pready;
	logic        o_pslverr;
	logic [31:0] o_prdata;
	logic        o_irq;
	logic        o_wake;
	logic        o_baud_tick;
	logic        o_busy;
	logic        o_done;
	logic [31:0] rd;
	logic        err;
	int          bad_count  = 0;
	int          n_compared = 0;
	int          n;
	logic [7:0]  txsc_tab [3] = '{8'h00, 8'h04, 8'h14};
	int          per_tab  [3] = '{192, 48, 12};

	always #10 i_clk = ~i_clk;

	serial_link_if serial_link_if_i ();
	serial_rx_dev #(.FIFO_DEPTH(2)) serial_rx_dev_i (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_prdata(o_prdata), .i_sleep(i_sleep), .o_irq(o_irq),
		.o_wake(o_wake), .o_baud_tick(o_baud_tick), .link(serial_link_if_i)
	);
	serial_sync_master #(.HALF_CYCLES(HALF)) serial_sync_master_i (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(i_start),
		.i_nine(i_nine), .i_word(i_word), .o_busy(o_busy),
		.o_done(o_done), .link(serial_link_if_i)
	);
	serial_link_chk #(.HALF(HALF)) serial_link_chk_i (
		.i_clk(i_clk), .i_rst_n(i_rst_n),
		.bit_clk(serial_link_if_i.bit_clk),
		.bit_data(serial_link_if_i.bit_data), .i_start(i_start),
		.o_busy(o_busy), .o_done(o_done), .i_sleep(i_sleep),
		.o_irq(o_irq), .o_wake(o_wake), .o_baud_tick(o_baud_tick)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic fail(input string m);
		bad_count++;
		$display("unexpected at %0t: %s", $time, m);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e,
			input string m);
		n_compared++;
		if (g !== e) begin
			fail(m);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int k;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge i_clk);
			if (o_pready === 1'b1) break;
		end
		if (k == 20) begin
			fail("no pready");
			results();
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e, "register read");
	endtask

	task automatic wait_tick(input int bound);
		for (n = 0; n < bound; n++) begin
			@(posedge i_clk);
			if (o_baud_tick === 1'b1) break;
		end
		if (n == bound) begin
			fail("no baud tick");
			results();
		end
	endtask

	task automatic send(input logic nine, input logic [8:0] w);
		int k;
		@(posedge i_clk);
		i_start <= 1'b1;
		i_nine <= nine;
		i_word <= w;
		@(posedge i_clk);
		i_start <= 1'b0;
		for (k = 0; k < 400; k++) begin
			@(posedge i_clk);
			if (o_done === 1'b1) break;
		end
		if (k == 400) begin
			fail("no done");
			results();
		end
		repeat (4) @(posedge i_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rdc(TX_STATUS_CONTROL_OFS, 32'h02);
		rdc(RX_STATUS_CONTROL_OFS, 32'h00);
		rdc(BAUD_DIVISOR_OFS, 32'h00);
		rdc(RX_DATA_OFS, 32'h00);
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped access not refused");
		chk(rd, 32'h0, "unmapped read data");
		// Async low, async high, sync with high rate set; divisor 2
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, BAUD_DIVISOR_OFS, 32'hFF);
			apb(1'b1, TX_STATUS_CONTROL_OFS, {24'h0, txsc_tab[m]});
			apb(1'b1, BAUD_DIVISOR_OFS, 32'h02);
			wait_tick(per_tab[m] + 3);
			wait_tick(per_tab[m] + 3);
			chk(32'(n + 1), 32'(per_tab[m]), "baud period");
		end
		// Slave receive in sleep, single receive enable also set
		apb(1'b1, INT_MASK_OFS, 32'h1);
		apb(1'b1, RX_STATUS_CONTROL_OFS, 32'hB0);
		i_sleep <= 1'b1;
		send(1'b0, 9'h0A5);
		chk({31'h0, o_irq}, 32'h1, "irq after word");
		chk({31'h0, o_wake}, 32'h1, "no wake in sleep");
		rdc(INT_STATUS_OFS, 32'h1);
		rdc(RX_DATA_OFS, 32'hA5);
		apb(1'b1, INT_STATUS_OFS, 32'h1);
		i_sleep <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk({31'h0, o_irq}, 32'h0, "irq after clear");
		// Masked word: flag set, no interrupt
		apb(1'b1, INT_MASK_OFS, 32'h0);
		send(1'b0, 9'h03C);
		chk({31'h0, o_irq}, 32'h0, "irq while masked");
		rdc(INT_STATUS_OFS, 32'h1);
		rdc(RX_DATA_OFS, 32'h3C);
		apb(1'b1, INT_STATUS_OFS, 32'h1);
		// Nine-bit word: ninth bit read before data
		apb(1'b1, RX_STATUS_CONTROL_OFS, 32'hD0);
		send(1'b1, 9'h15A);
		rdc(RX_STATUS_CONTROL_OFS, 32'hD1);
		rdc(RX_DATA_OFS, 32'h5A);
		// Three words into a two-deep FIFO
		apb(1'b1, RX_STATUS_CONTROL_OFS, 32'h90);
		send(1'b0, 9'h011);
		send(1'b0, 9'h022);
		send(1'b0, 9'h033);
		rdc(RX_STATUS_CONTROL_OFS, 32'h92);
		rdc(INT_STATUS_OFS, 32'h3);
		rdc(RX_DATA_OFS, 32'h11);
		rdc(RX_DATA_OFS, 32'h22);
		rdc(RX_STATUS_CONTROL_OFS, 32'h92);
		apb(1'b1, RX_STATUS_CONTROL_OFS, 32'h80);
		rdc(RX_STATUS_CONTROL_OFS, 32'h80);
		apb(1'b1, RX_STATUS_CONTROL_OFS, 32'h90);
		send(1'b0, 9'h044);
		rdc(RX_DATA_OFS, 32'h44);
		// Clock source select set: no slave reception
		apb(1'b1, INT_STATUS_OFS, 32'h3);
		apb(1'b1, TX_STATUS_CONTROL_OFS, 32'h94);
		rdc(TX_STATUS_CONTROL_OFS, 32'h96);
		send(1'b0, 9'h055);
		rdc(INT_STATUS_OFS, 32'h0);
		rdc(RX_DATA_OFS, 32'h0);
		results();
	end
endmodule
`default_nettype wire
